/* bser_pkg.sv */
// Package of constants and types for the bridge system-error reporting unit
package bser_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_STATUS   = 4'h1;
    localparam logic [3:0] ADDR_CAUSE    = 4'h2;
    localparam logic [3:0] ADDR_DISABLE  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h6;
    localparam logic [3:0] ADDR_RETRY    = 4'h7;

    // Control register bit positions
    localparam int CTL_SERR_EN    = 0;
    localparam int CTL_PRI_PER    = 1;
    localparam int CTL_SEC_PER    = 2;
    localparam int CTL_FWD_EN     = 3;
    localparam int CTL_MTO_SERR   = 4;
    localparam int CTL_MABORT_MOD = 5;

    // Status register bit positions
    localparam int STS_SIG_SERR = 0;
    localparam int STS_RCV_SERR = 1;

    // Cause codes: bit index in cause, disable and interrupt registers
    localparam int NCAUSE     = 8;
    localparam int CS_PARITY  = 0;
    localparam int CS_SEC_ERR = 1;
    localparam int CS_TABORT  = 2;
    localparam int CS_MABORT  = 3;
    localparam int CS_PW_RTY  = 4;
    localparam int CS_DW_RTY  = 5;
    localparam int CS_DR_RTY  = 6;
    localparam int CS_MTO     = 7;

    // Transaction kinds of the retry counter
    localparam logic [1:0] TK_POSTED  = 2'h0;
    localparam logic [1:0] TK_DLY_WR  = 2'h1;
    localparam logic [1:0] TK_DLY_RD  = 2'h2;

    // Retry limit, two to the 24th by default
    localparam logic [24:0] RETRY_LIMIT_DEF = 25'h1000000;

    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DIS  = 8'h00;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_DRIVE
    } bser_pin_t;

endpackage

/* bser_core.sv */
// System-error reporting unit of a two-port bridge, primary side
//
// Overview of operation
// RQ1: Target-bus parity error on posted write signals error
// RQ2: Skip if parity already seen as target
// RQ3: Needs both parity responses; posted writes only
// RQ4: Never assert without command system-error enable
// RQ5: Each assertion sets signaled-system-error status
// RQ6: Secondary error input forwarded when enabled
// RQ7: Secondary error input sets received-error status
// RQ8: Target abort on posted write is cause
// RQ9: Master abort on posted write is cause
// RQ10: Posted write retry exhaustion is cause
// RQ11: Delayed write retry exhaustion is cause
// RQ12: Delayed read retry exhaustion is cause
// RQ13: Master timeout on delayed transaction is cause
// RQ14: Cause register records which event asserted
// RQ15: Per-cause disable bits except master timeout
// RQ16: Master timeout gated by bridge-control enable
// RQ17: Retry counter cleared on accept, flags limit
// RQ18: Open-drain low pulse, one clock per event
//
// Implementation choices: the plain strobed port and the register offsets.
module bser_core
    import bser_pkg::*;
#(
    parameter logic [24:0] RETRY_LIMIT = RETRY_LIMIT_DEF
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Error sources, one-cycle pulses
    input  wire logic        i_pri_parity_err_n,
    input  wire logic        i_sec_parity_err_n,
    input  wire logic        i_pw_active,
    input  wire logic        i_pw_upstream,
    input  wire logic        i_pw_seen_as_target,
    input  wire logic        i_sec_sys_err_in_n,
    input  wire logic        i_pw_target_abort,
    input  wire logic        i_pw_master_abort,
    input  wire logic        i_master_timeout,
    // Retry tracking for the transaction at the head of the queue
    input  wire logic        i_retry,
    input  wire logic        i_accept,
    input  wire logic [1:0]  i_txn_kind,
    // Discard request back to the queue
    output logic             o_discard,
    // System-error pin
    output logic             o_pri_sys_err_n_o,
    output logic             o_pri_sys_err_n_oe,
    // Interrupt
    output logic             o_irq
);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [1:0]  status;
        logic [NCAUSE-1:0] cause;
        logic [NCAUSE-1:0] dis;
        logic [NCAUSE-1:0] irq_stat;
        logic [NCAUSE-1:0] irq_en;
        logic [24:0] retry_cnt;
        logic [24:0] retry_lim;
        logic        discard;
        bser_pin_t   pin;
        logic        pin_o;
        logic        pin_oe;
        logic        irq;
        logic [31:0] rdata;
    } bser_state_t;

    bser_state_t st;
    bser_state_t next_st;

    logic [NCAUSE-1:0] ev;
    logic [NCAUSE-1:0] fire;
    logic              rty_hit;

    // Write decode used for several registers
    function automatic logic wr_hit(input logic [3:0] a,
                                    input logic [3:0] ref_a);
        wr_hit = i_wr && (a == ref_a);
    endfunction

    always_comb begin
        rty_hit = i_retry && (st.retry_cnt + 25'h0000001 >= st.retry_lim);
        ev = '0;
        // Only posted writes, parity reported on the target bus
        ev[CS_PARITY] = i_pw_active && !i_pw_seen_as_target &&          // [RQ2]
            (i_pw_upstream ? !i_pri_parity_err_n                     // [RQ1]
                           : !i_sec_parity_err_n) &&
            st.ctrl[CTL_PRI_PER] && st.ctrl[CTL_SEC_PER];            // [RQ3]
        ev[CS_SEC_ERR] = !i_sec_sys_err_in_n;
        ev[CS_TABORT]  = i_pw_target_abort;                          // [RQ8]
        ev[CS_MABORT]  = i_pw_master_abort &&                        // [RQ9]
            st.ctrl[CTL_MABORT_MOD];
        ev[CS_PW_RTY]  = rty_hit && (i_txn_kind == TK_POSTED);       // [RQ10]
        ev[CS_DW_RTY]  = rty_hit && (i_txn_kind == TK_DLY_WR);       // [RQ11]
        ev[CS_DR_RTY]  = rty_hit && (i_txn_kind == TK_DLY_RD);       // [RQ12]
        ev[CS_MTO]     = i_master_timeout;                           // [RQ13]

        fire = ev & ~st.dis;                                         // [RQ15]
        fire[CS_SEC_ERR] = ev[CS_SEC_ERR] && st.ctrl[CTL_FWD_EN] &&  // [RQ6]
            !st.dis[CS_SEC_ERR];
        fire[CS_MTO] = ev[CS_MTO] && st.ctrl[CTL_MTO_SERR];          // [RQ16]
        if (!st.ctrl[CTL_SERR_EN]) begin
            fire = '0;                                               // [RQ4]
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdata = 32'h00000000;

        // Retry counter per transaction
        if (i_accept || rty_hit) begin
            next_st.retry_cnt = 25'h0000000;                         // [RQ17]
        end else if (i_retry) begin
            next_st.retry_cnt = st.retry_cnt + 25'h0000001;
        end
        next_st.discard = rty_hit;                                   // [RQ17]

        // Register writes
        if (wr_hit(i_addr, ADDR_CTRL)) begin
            next_st.ctrl = i_wdata[7:0];
        end
        if (wr_hit(i_addr, ADDR_DISABLE)) begin
            next_st.dis = i_wdata[NCAUSE-1:0];
        end
        if (wr_hit(i_addr, ADDR_IRQ_EN)) begin
            next_st.irq_en = i_wdata[NCAUSE-1:0];
        end
        if (wr_hit(i_addr, ADDR_RETRY)) begin
            next_st.retry_lim = (i_wdata[24:0] == 25'h0000000) ?
                                25'h0000001 : i_wdata[24:0];
        end
        // Status and cause: write one to clear, set wins
        if (wr_hit(i_addr, ADDR_STATUS)) begin
            next_st.status = st.status & ~i_wdata[1:0];
        end
        if (wr_hit(i_addr, ADDR_CAUSE)) begin
            next_st.cause = st.cause & ~i_wdata[NCAUSE-1:0];
        end
        if (wr_hit(i_addr, ADDR_IRQ_CLR)) begin
            next_st.irq_stat = st.irq_stat & ~i_wdata[NCAUSE-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | ev;
        next_st.cause = next_st.cause | fire;                        // [RQ14]
        if (ev[CS_SEC_ERR]) begin
            next_st.status[STS_RCV_SERR] = 1'b1;                     // [RQ7]
        end
        if (|fire) begin
            next_st.status[STS_SIG_SERR] = 1'b1;                     // [RQ5]
        end

        // Pin drives low for exactly the cycle after an event
        unique case (st.pin)
            PIN_IDLE: begin
                if (|fire) begin
                    next_st.pin = PIN_DRIVE;                         // [RQ18]
                end
            end
            PIN_DRIVE: begin
                if (!(|fire)) begin
                    next_st.pin = PIN_IDLE;
                end
            end
        endcase
        next_st.pin_o  = 1'b0;
        next_st.pin_oe = |fire;                                      // [RQ18]

        next_st.irq = |(next_st.irq_stat & next_st.irq_en);

        if (i_rd) begin
            unique case (i_addr)
                ADDR_CTRL:     next_st.rdata = {24'h000000, st.ctrl};
                ADDR_STATUS:   next_st.rdata = {30'h00000000, st.status};
                ADDR_CAUSE:    next_st.rdata = {24'h000000, st.cause};
                ADDR_DISABLE:  next_st.rdata = {24'h000000, st.dis};
                ADDR_IRQ_STAT: next_st.rdata = {24'h000000, st.irq_stat};
                ADDR_IRQ_EN:   next_st.rdata = {24'h000000, st.irq_en};
                ADDR_RETRY:    next_st.rdata = {7'h00, st.retry_lim};
                default:       next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st.ctrl      <= RST_CTRL;
            st.status    <= 2'h0;
            st.cause     <= '0;
            st.dis       <= RST_DIS;
            st.irq_stat  <= '0;
            st.irq_en    <= '0;
            st.retry_cnt <= 25'h0000000;
            st.retry_lim <= RETRY_LIMIT;
            st.discard   <= 1'b0;
            st.pin       <= PIN_IDLE;
            st.pin_o     <= 1'b0;
            st.pin_oe    <= 1'b0;
            st.irq       <= 1'b0;
            st.rdata     <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata            = st.rdata;
    assign o_discard          = st.discard;
    assign o_pri_sys_err_n_o  = st.pin_o;
    assign o_pri_sys_err_n_oe = st.pin_oe;
    assign o_irq              = st.irq;

    // Assertions
    AST_NO_SERR_WITHOUT_EN: assert property (@(posedge i_clk) // [RQ4]
        disable iff (!i_rst_b)
        !st.ctrl[CTL_SERR_EN] |=> !o_pri_sys_err_n_oe)
        else $error("system error driven while disabled");

    AST_SIG_STATUS: assert property (@(posedge i_clk) // [RQ5]
        disable iff (!i_rst_b)
        $rose(o_pri_sys_err_n_oe) |-> st.status[STS_SIG_SERR])
        else $error("signaled status not set");

    AST_PULSE: assert property (@(posedge i_clk) // [RQ18]
        disable iff (!i_rst_b)
        (|fire) |=> o_pri_sys_err_n_oe && !o_pri_sys_err_n_o)
        else $error("pin not driven low after event");

    AST_NO_SPURIOUS: assert property (@(posedge i_clk) // [RQ18]
        disable iff (!i_rst_b)
        !(|fire) |=> !o_pri_sys_err_n_oe)
        else $error("pin driven without event");

    AST_RCV_STATUS: assert property (@(posedge i_clk) // [RQ7]
        disable iff (!i_rst_b)
        !i_sec_sys_err_in_n |=> st.status[STS_RCV_SERR])
        else $error("received status not set");

    AST_FWD: assert property (@(posedge i_clk) // [RQ6]
        disable iff (!i_rst_b)
        !i_sec_sys_err_in_n && st.ctrl[CTL_SERR_EN] &&
        st.ctrl[CTL_FWD_EN] && !st.dis[CS_SEC_ERR]
        |=> o_pri_sys_err_n_oe)
        else $error("secondary error not forwarded");

    AST_PARITY_TGT: assert property (@(posedge i_clk) // [RQ2]
        disable iff (!i_rst_b)
        i_pw_seen_as_target |-> !fire[CS_PARITY])
        else $error("parity reported though seen as target");

    AST_PARITY_BOTH: assert property (@(posedge i_clk) // [RQ3]
        disable iff (!i_rst_b)
        fire[CS_PARITY] |-> st.ctrl[CTL_PRI_PER] && st.ctrl[CTL_SEC_PER])
        else $error("parity reported without both responses");

    AST_CAUSE: assert property (@(posedge i_clk) // [RQ14]
        disable iff (!i_rst_b)
        (|fire) |=> |(st.cause & $past(fire)))
        else $error("cause not recorded");

    AST_MTO_GATE: assert property (@(posedge i_clk) // [RQ16]
        disable iff (!i_rst_b)
        i_master_timeout && !st.ctrl[CTL_MTO_SERR] |-> !fire[CS_MTO])
        else $error("timeout reported while disabled");

    AST_DISCARD: assert property (@(posedge i_clk) // [RQ17]
        disable iff (!i_rst_b)
        rty_hit |=> o_discard && st.retry_cnt == 25'h0000000)
        else $error("retry limit not handled");

    // Each parity direction must reach the pin when fully enabled
    AST_PAR_UP: assert property (@(posedge i_clk) // [RQ1]
        disable iff (!i_rst_b)
        i_pw_active && i_pw_upstream && !i_pri_parity_err_n &&
        !i_pw_seen_as_target && st.ctrl[CTL_SERR_EN] &&
        st.ctrl[CTL_PRI_PER] && st.ctrl[CTL_SEC_PER] &&
        !st.dis[CS_PARITY]
        |=> o_pri_sys_err_n_oe && st.cause[CS_PARITY])
        else $error("upstream parity error not reported");

    AST_PAR_DN: assert property (@(posedge i_clk) // [RQ1]
        disable iff (!i_rst_b)
        i_pw_active && !i_pw_upstream && !i_sec_parity_err_n &&
        !i_pw_seen_as_target && st.ctrl[CTL_SERR_EN] &&
        st.ctrl[CTL_PRI_PER] && st.ctrl[CTL_SEC_PER] &&
        !st.dis[CS_PARITY]
        |=> o_pri_sys_err_n_oe && st.cause[CS_PARITY])
        else $error("downstream parity error not reported");

    AST_PAR_PW_ONLY: assert property (@(posedge i_clk) // [RQ3]
        disable iff (!i_rst_b)
        !i_pw_active |-> !fire[CS_PARITY])
        else $error("parity reported outside posted write");

    AST_OE_NEEDS_EN: assert property (@(posedge i_clk) // [RQ4]
        disable iff (!i_rst_b)
        o_pri_sys_err_n_oe |-> $past(st.ctrl[CTL_SERR_EN]))
        else $error("pin driven after disabled cycle");

    AST_SIG_HELD: assert property (@(posedge i_clk) // [RQ5]
        disable iff (!i_rst_b)
        o_pri_sys_err_n_oe |-> st.status[STS_SIG_SERR])
        else $error("pin driven with signaled status clear");

    AST_FWD_OFF: assert property (@(posedge i_clk) // [RQ6]
        disable iff (!i_rst_b)
        !st.ctrl[CTL_FWD_EN] |-> !fire[CS_SEC_ERR])
        else $error("secondary error forwarded while disabled");

    AST_TABORT: assert property (@(posedge i_clk) // [RQ8]
        disable iff (!i_rst_b)
        i_pw_target_abort && st.ctrl[CTL_SERR_EN] && !st.dis[CS_TABORT]
        |=> o_pri_sys_err_n_oe && st.cause[CS_TABORT])
        else $error("target abort not reported");

    AST_MABORT: assert property (@(posedge i_clk) // [RQ9]
        disable iff (!i_rst_b)
        i_pw_master_abort && st.ctrl[CTL_SERR_EN] &&
        st.ctrl[CTL_MABORT_MOD] && !st.dis[CS_MABORT]
        |=> o_pri_sys_err_n_oe && st.cause[CS_MABORT])
        else $error("master abort not reported");

    AST_MABORT_MODE: assert property (@(posedge i_clk) // [RQ9]
        disable iff (!i_rst_b)
        !st.ctrl[CTL_MABORT_MOD] |-> !fire[CS_MABORT])
        else $error("master abort reported with mode clear");

    AST_PW_RTY: assert property (@(posedge i_clk) // [RQ10]
        disable iff (!i_rst_b)
        rty_hit && i_txn_kind == TK_POSTED && st.ctrl[CTL_SERR_EN] &&
        !st.dis[CS_PW_RTY]
        |=> o_pri_sys_err_n_oe && st.cause[CS_PW_RTY])
        else $error("posted retry discard not reported");

    AST_DW_RTY: assert property (@(posedge i_clk) // [RQ11]
        disable iff (!i_rst_b)
        rty_hit && i_txn_kind == TK_DLY_WR && st.ctrl[CTL_SERR_EN] &&
        !st.dis[CS_DW_RTY]
        |=> o_pri_sys_err_n_oe && st.cause[CS_DW_RTY])
        else $error("delayed write retry discard not reported");

    AST_DR_RTY: assert property (@(posedge i_clk) // [RQ12]
        disable iff (!i_rst_b)
        rty_hit && i_txn_kind == TK_DLY_RD && st.ctrl[CTL_SERR_EN] &&
        !st.dis[CS_DR_RTY]
        |=> o_pri_sys_err_n_oe && st.cause[CS_DR_RTY])
        else $error("delayed read retry discard not reported");

    AST_MTO: assert property (@(posedge i_clk) // [RQ13]
        disable iff (!i_rst_b)
        i_master_timeout && st.ctrl[CTL_SERR_EN] && st.ctrl[CTL_MTO_SERR]
        |=> o_pri_sys_err_n_oe && st.cause[CS_MTO])
        else $error("master timeout not reported");

    // Master timeout is left out: its gate lives in the control register
    AST_DIS: assert property (@(posedge i_clk) // [RQ15]
        disable iff (!i_rst_b)
        !(|(fire[CS_DR_RTY:CS_PARITY] & st.dis[CS_DR_RTY:CS_PARITY])))
        else $error("disabled cause reported");

    AST_RTY_CLR: assert property (@(posedge i_clk) // [RQ17]
        disable iff (!i_rst_b)
        i_accept |=> st.retry_cnt == 25'h0000000)
        else $error("retry counter not cleared on accept");

    AST_RTY_INC: assert property (@(posedge i_clk) // [RQ17]
        disable iff (!i_rst_b)
        i_retry && !i_accept && !rty_hit
        |=> st.retry_cnt == $past(st.retry_cnt) + 25'h0000001)
        else $error("retry counter did not advance");

    AST_NO_DISCARD: assert property (@(posedge i_clk) // [RQ17]
        disable iff (!i_rst_b)
        !i_retry |=> !o_discard)
        else $error("discard without a retry");

    // The state register shadows the enable so a stuck pin shows up
    AST_PIN_STATE: assert property (@(posedge i_clk) // [RQ18]
        disable iff (!i_rst_b)
        (st.pin == PIN_DRIVE) == o_pri_sys_err_n_oe)
        else $error("pin state and drive disagree");

    AST_PIN_LOW: assert property (@(posedge i_clk) // [RQ18]
        disable iff (!i_rst_b)
        !o_pri_sys_err_n_o)
        else $error("open-drain pin drives high");

endmodule

/* bser_host.sv */
// Host-side model of the primary system-error line and its pull-up
module bser_host (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Open-drain pin as driven by the bridge
    input  wire logic        i_drv_o,
    input  wire logic        i_drv_oe,
    // Resolved line and count of low cycles seen
    output wire logic        o_line,
    output logic      [15:0] o_low_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pull-up: an undriven line reads high, never the last driven value
    assign o_line = i_drv_oe ? i_drv_o : 1'b1;

    // Host counts one reported event per low cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_low_cnt <= '0;
        end else if (!o_line) begin
            o_low_cnt <= o_low_cnt + 16'h1;
        end
    end
endmodule

/* tb.sv */
// Testbench of the bridge system-error reporting unit
module tb
    import bser_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst_b, wr, rd, retry, accept;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    logic [8:0]  ev;
    logic [1:0]  kind;
    logic        discard, so, soe, irq;
    wire         pin;
    logic [15:0] n_low;
    int          n_mismatch, cmp_count, n_exp_low;

    bser_core i_bser_core (
        .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_pri_parity_err_n(~ev[3]), .i_sec_parity_err_n(~ev[4]),
        .i_pw_active(ev[0]), .i_pw_upstream(ev[1]),
        .i_pw_seen_as_target(ev[2]), .i_sec_sys_err_in_n(~ev[5]),
        .i_pw_target_abort(ev[6]), .i_pw_master_abort(ev[7]),
        .i_master_timeout(ev[8]), .i_retry(retry), .i_accept(accept),
        .i_txn_kind(kind), .o_discard(discard),
        .o_pri_sys_err_n_o(so), .o_pri_sys_err_n_oe(soe), .o_irq(irq));

    bser_host i_bser_host (
        .i_clk(clk), .i_rst_b(rst_b), .i_drv_o(so), .i_drv_oe(soe),
        .o_line(pin), .o_low_cnt(n_low));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic clr();
        wr_reg(ADDR_CAUSE, 32'hFF);
        wr_reg(ADDR_STATUS, 32'h3);
    endtask

    task automatic fire(input logic [8:0] v, input logic e,
                        input logic [7:0] c);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= '0;
        #1 chk({soe, pin}, {e, ~e});
        n_exp_low += e;
        @(posedge clk);
        #1 chk(soe, 1'b0);
        rd_reg(ADDR_STATUS, {30'h0, v[5], e});
        if (e) rd_reg(ADDR_CAUSE, {24'h0, c});
        clr();
        $display("%0t event %h done", $time, v);
    endtask

    task automatic rtry(input logic [1:0] k, input int n, input logic e);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            retry <= 1'b1;
            kind <= k;
            @(posedge clk);
            retry <= 1'b0;
            #1 chk({discard, soe}, {2{(i == n - 1) && e}});
        end
        n_exp_low += e;
        if (e) rd_reg(ADDR_CAUSE, 32'h10 << k);
        clr();
        $display("%0t retry kind %0d done", $time, k);
    endtask

    task automatic conclude();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        {rst_b, wr, rd, retry, accept, addr, wdata, ev, kind} = '0;
        n_exp_low = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(ADDR_CTRL, 32'h0);
        rd_reg(ADDR_DISABLE, 32'h0);
        rd_reg(ADDR_RETRY, 32'h1000000);
        fire(9'h040, 1'b0, 8'h00);
        wr_reg(ADDR_CTRL, 32'h3F);
        fire(9'h00B, 1'b1, 8'h01);
        fire(9'h011, 1'b1, 8'h01);
        fire(9'h00F, 1'b0, 8'h00);
        fire(9'h008, 1'b0, 8'h00);
        fire(9'h020, 1'b1, 8'h02);
        fire(9'h040, 1'b1, 8'h04);
        fire(9'h080, 1'b1, 8'h08);
        fire(9'h100, 1'b1, 8'h80);
        wr_reg(ADDR_CTRL, 32'h3D);
        fire(9'h00B, 1'b0, 8'h00);
        wr_reg(ADDR_CTRL, 32'h29);
        fire(9'h100, 1'b0, 8'h00);
        fire(9'h011, 1'b0, 8'h00);
        wr_reg(ADDR_CTRL, 32'h3F);
        wr_reg(ADDR_DISABLE, 32'h84);
        fire(9'h040, 1'b0, 8'h00);
        fire(9'h020, 1'b1, 8'h02);
        fire(9'h100, 1'b1, 8'h80);
        wr_reg(ADDR_DISABLE, 32'h0);
        // Short limit keeps the run brief; counts scale with it
        wr_reg(ADDR_RETRY, 32'h4);
        rd_reg(ADDR_RETRY, 32'h4);
        rtry(TK_POSTED, 4, 1'b1);
        rtry(TK_DLY_WR, 4, 1'b1);
        rtry(TK_DLY_RD, 4, 1'b1);
        rtry(TK_POSTED, 2, 1'b0);
        @(posedge clk);
        accept <= 1'b1;
        @(posedge clk);
        accept <= 1'b0;
        rtry(TK_POSTED, 3, 1'b0);
        rtry(TK_POSTED, 1, 1'b1);
        wr_reg(ADDR_IRQ_CLR, 32'hFF);
        wr_reg(ADDR_IRQ_EN, 32'h04);
        rd_reg(ADDR_IRQ_STAT, 32'h0);
        fire(9'h080, 1'b1, 8'h08);
        #1 chk(irq, 1'b0);
        rd_reg(ADDR_IRQ_STAT, 32'h08);
        fire(9'h040, 1'b1, 8'h04);
        #1 chk(irq, 1'b1);
        rd_reg(ADDR_IRQ_STAT, 32'h0C);
        wr_reg(ADDR_IRQ_CLR, 32'h04);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0);
        rd_reg(ADDR_IRQ_STAT, 32'h08);
        rd_reg(4'hF, 32'h0);
        chk(n_low, n_exp_low[15:0]);
        conclude();
    end
endmodule
